// [hw/tsofc_counters.sv]
// Offload-failure and legacy interrupt statistics counters with APB slave
`timescale 1ns/1ps
`include "tsofc_regs.svh"

// How it works
// R1: Each offload context that fails to send its whole payload bumps the failure count.
// R2: A context is counted at most once, whatever number of faults it sees.
// R3: Failures are counted only while the transmit path is enabled.
// R4: No measure of bytes sent for a failed context exists; only the count.
// R5: A bad payload length for a context counts as a failure cause.
// R6: Read-only 32-bit interrupt total, zero at reset, one per legacy assertion.
// R7: Physical-layer registers are reached through the management access register, not here.
// R8: The failure count is a full 32-bit field and resets to zero.
module tsofc_counters
  import tsofc_pkg::*;
#(
  parameter int CNT_W = `TSOFC_CNT_W
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Segmentation engine events
  input  wire tsofc_seg_ev_t seg_ev,
  input  wire logic          tx_enable,
  // Legacy interrupt line, high while asserted
  input  wire logic          legacy_irq
);

  // Register address match, used by write decode and error decode
  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a == `TSOFC_IAT_OFF) || (a == `TSOFC_SCF_OFF) ||
                (a == `TSOFC_CTRL_OFF) || (a == `TSOFC_STAT_OFF);
  endfunction : is_mapped

  // ---------------------------------------------------------------
  // Bus phases
  // ---------------------------------------------------------------
  logic apb_setup;
  logic apb_access;
  logic apb_wr;

  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pwrite && is_mapped(paddr);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic        freeze_r;
  logic        freeze_nxt;
  tsofc_ctrl_t ctrl;

  always_comb begin
    freeze_nxt = freeze_r;
    ctrl.clear  = 1'b0;
    ctrl.freeze = freeze_r;
    if (apb_wr && (paddr == `TSOFC_CTRL_OFF) && pstrb[0]) begin
      freeze_nxt = pwdata[`TSOFC_CTRL_FREEZE_B];
      ctrl.clear = pwdata[`TSOFC_CTRL_CLEAR_B];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze_r <= `TSOFC_CTRL_RST;
    end else begin
      freeze_r <= freeze_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Segmentation context tracking
  // ---------------------------------------------------------------
  tsofc_ctx_st_t ctx_st_r;
  tsofc_ctx_st_t ctx_st_nxt;
  logic          ctx_live;
  logic          ctx_already_failed;
  logic          fail_cause;
  logic          fail_hit;
  logic          fail_inc;

  always_comb begin
    // A start opens a fresh context even if the previous one never closed
    ctx_live           = seg_ev.start || (ctx_st_r != TSOFC_IDLE);
    ctx_already_failed = (ctx_st_r == TSOFC_FAILED) && !seg_ev.start;          // see R2
    fail_cause         = seg_ev.fault || seg_ev.paylen_err;                    // see R5
    fail_hit           = ctx_live && fail_cause && tx_enable &&                // see R3
                         !ctx_already_failed;                                  // see R2
    fail_inc           = fail_hit && !ctrl.freeze;                             // see R1

    ctx_st_nxt = ctx_st_r;
    unique case (ctx_st_r)
      TSOFC_IDLE: begin
        if (seg_ev.start && !seg_ev.done) begin
          ctx_st_nxt = fail_hit ? TSOFC_FAILED : TSOFC_ACTIVE;
        end
      end
      TSOFC_ACTIVE: begin
        if (seg_ev.done && !seg_ev.start) begin
          ctx_st_nxt = TSOFC_IDLE;
        end else if (fail_hit) begin
          ctx_st_nxt = TSOFC_FAILED;                                          // see R2
        end else begin
          ctx_st_nxt = TSOFC_ACTIVE;
        end
      end
      TSOFC_FAILED: begin
        if (seg_ev.done && !seg_ev.start) begin
          ctx_st_nxt = TSOFC_IDLE;
        end else if (seg_ev.start) begin
          ctx_st_nxt = fail_hit ? TSOFC_FAILED : TSOFC_ACTIVE;
        end else begin
          ctx_st_nxt = TSOFC_FAILED;
        end
      end
      default: begin
        ctx_st_nxt = TSOFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_st_r <= TSOFC_IDLE;
    end else begin
      ctx_st_r <= ctx_st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Legacy interrupt assertion detect
  // ---------------------------------------------------------------
  logic irq_d_r;
  logic irq_d_nxt;
  logic irq_rise;

  always_comb begin
    irq_d_nxt = legacy_irq;
    irq_rise  = legacy_irq && !irq_d_r;                                       // see R6
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_d_r <= 1'b0;
    end else begin
      irq_d_r <= irq_d_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] seg_context_fail_count;
  logic [CNT_W-1:0] interrupt_assertion_total;

  tsofc_cnt32 #(
    .W       (CNT_W)
  ) u_fail_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (fail_inc),                                                      // see R1
    .clr     (ctrl.clear),
    .count   (seg_context_fail_count)                                         // see R8
  );

  tsofc_cnt32 #(
    .W       (CNT_W)
  ) u_irq_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (irq_rise && !ctrl.freeze),                                      // see R6
    .clr     (ctrl.clear),
    .count   (interrupt_assertion_total)
  );

  // ---------------------------------------------------------------
  // Read path: data captured in the setup cycle, returned in access
  // ---------------------------------------------------------------
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (apb_setup) begin
      rdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          (paddr == `TSOFC_IAT_OFF): begin
            rdata_nxt = 32'(interrupt_assertion_total);                       // see R6
          end
          // Only the count is kept; nothing reports bytes sent
          (paddr == `TSOFC_SCF_OFF): begin
            rdata_nxt = 32'(seg_context_fail_count);                          // see R4
          end
          (paddr == `TSOFC_CTRL_OFF): begin
            rdata_nxt[`TSOFC_CTRL_FREEZE_B] = freeze_r;
          end
          (paddr == `TSOFC_STAT_OFF): begin
            rdata_nxt[`TSOFC_STAT_ACTIVE_B] = (ctx_st_r != TSOFC_IDLE);
            rdata_nxt[`TSOFC_STAT_FAILED_B] = (ctx_st_r == TSOFC_FAILED);
            rdata_nxt[`TSOFC_STAT_TXEN_B]   = tx_enable;
          end
          default: begin
            rdata_nxt = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Zero wait states; physical-layer space is not decoded and errors out
  assign pready  = 1'b1;
  assign pslverr = apb_access && !is_mapped(paddr);                           // see R7
  assign prdata  = rdata_r;

endmodule : tsofc_counters

// [hw/tsofc_regs.svh]
// Register offsets, field positions and reset values of the offload-failure and interrupt counters
`ifndef TSOFC_REGS_SVH
`define TSOFC_REGS_SVH

// Byte addresses on the APB register bus
`define TSOFC_IAT_OFF        32'h0000_4100
`define TSOFC_SCF_OFF        32'h0000_4104
`define TSOFC_CTRL_OFF       32'h0000_4108
`define TSOFC_STAT_OFF       32'h0000_410C

// Counter geometry and reset values
`define TSOFC_CNT_W          32
`define TSOFC_IAT_RST        32'h0000_0000
`define TSOFC_SCF_RST        32'h0000_0000

// Control register fields
`define TSOFC_CTRL_FREEZE_B  0
`define TSOFC_CTRL_CLEAR_B   1
`define TSOFC_CTRL_RST       1'b0

// Status register fields
`define TSOFC_STAT_ACTIVE_B  0
`define TSOFC_STAT_FAILED_B  1
`define TSOFC_STAT_TXEN_B    2

`endif

// [hw/tsofc_pkg.sv]
// Types shared by the offload-failure and interrupt counter block
package tsofc_pkg;

  // Events from the segmentation engine, one cycle each
  typedef struct packed {
    logic start;
    logic fault;
    logic paylen_err;
    logic done;
  } tsofc_seg_ev_t;

  // Per-context tracking state
  typedef enum logic [1:0] {
    TSOFC_IDLE   = 2'b00,
    TSOFC_ACTIVE = 2'b01,
    TSOFC_FAILED = 2'b10
  } tsofc_ctx_st_t;

  // Software controls decoded from a register write
  typedef struct packed {
    logic clear;
    logic freeze;
  } tsofc_ctrl_t;

endpackage : tsofc_pkg

// [hw/tsofc_cnt32.sv]
// Wrapping event counter with synchronous clear
`timescale 1ns/1ps
module tsofc_cnt32 #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         inc,
  input  wire logic         clr,
  // Count
  output logic [W-1:0]      count
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  // An increment coinciding with a clear is kept
  always_comb begin
    count_nxt = count_r;
    if (clr) begin
      count_nxt = inc ? W'(1) : '0;
    end else if (inc) begin
      count_nxt = count_r + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule : tsofc_cnt32

// [sim/tsofc_counters_props.sv]
// Concurrent checks on the APB side of the statistics counters
`timescale 1ns/1ps
`include "tsofc_regs.svh"
module tsofc_props #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic mapped;
  assign mapped = paddr inside {`TSOFC_IAT_OFF, `TSOFC_SCF_OFF, `TSOFC_CTRL_OFF, `TSOFC_STAT_OFF};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Read setup qualified by c, then its access cycle
  sequence s_rd(c);
    psel && !penable && !pwrite && c ##1 psel && penable;
  endsequence
  AST_READY: assert property (psel && penable |-> pready)
    else $error("ready missing in access");
  AST_UNMAP_ERR: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access without error");
  AST_MAP_OK: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped register");
  AST_IDLE_OK: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  AST_UNMAP_RD: assert property (s_rd(!mapped) |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (psel && penable && !pwrite ##1 !psel |-> $stable(prdata))
    else $error("read data moved after access");
  AST_STAT_PAD: assert property (s_rd(paddr == `TSOFC_STAT_OFF) |-> prdata[31:3] == 29'h0000_0000)
    else $error("status shows extra bits");
  AST_CTRL_PAD: assert property (s_rd(paddr == `TSOFC_CTRL_OFF) |-> prdata[31:1] == 31'h0000_0000)
    else $error("control shows extra bits");
endmodule : tsofc_props
bind tsofc_counters tsofc_props #(.CNT_W(CNT_W)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [sim/tso_fail_irq_stat_counters_bench.sv]
// Self-checking bench for the offload-failure and interrupt counters
`timescale 1ns/1ps
`include "tsofc_regs.svh"
module tso_fail_irq_stat_counters_bench
  import tsofc_pkg::*;
;
  logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic          pwrite = 1'b0, tx_enable = 1'b0, legacy_irq = 1'b0;
  logic [31:0]   paddr = '0, pwdata = '0, prdata, rdat;
  logic [3:0]    pstrb = 4'hF;
  logic          pready, pslverr, err;
  tsofc_seg_ev_t seg_ev = '0;
  int            num_errors = 0, num_checks = 0, cyc = 0;
  tsofc_counters i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .seg_ev(seg_ev), .tx_enable(tx_enable), .legacy_irq(legacy_irq));
  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input string n, input logic [31:0] a, e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, rdat, e);
  endtask : rd
  // One engine event cycle: start, fault, paylen_err, done from high bit down
  task automatic ev(input logic [3:0] e);
    seg_ev <= tsofc_seg_ev_t'(e);
    @(posedge pclk);
  endtask : ev
  task automatic t_reset();
    rd("iat", `TSOFC_IAT_OFF, `TSOFC_IAT_RST);
    rd("scf", `TSOFC_SCF_OFF, `TSOFC_SCF_RST);
    apb(1'b1, `TSOFC_IAT_OFF, 32'h0000_00FF);
    rd("iat ro", `TSOFC_IAT_OFF, 32'h0000_0000);
    rd("phy", 32'h0000_0020, 32'h0000_0000);
    chk("phy err", err, 32'h0000_0001);
  endtask : t_reset
  task automatic t_irq();
    for (int i = 0; i < 3; i++) begin
      legacy_irq <= 1'b1;
      repeat (i + 1) @(posedge pclk);
      legacy_irq <= 1'b0;
      @(posedge pclk);
    end
    rd("iat 3", `TSOFC_IAT_OFF, 32'h0000_0003);
  endtask : t_irq
  task automatic t_fail();
    tx_enable <= 1'b1;
    ev(4'h8);
    ev(4'h1);
    ev(4'h8);
    ev(4'h4);
    ev(4'h2);
    ev(4'h0);
    rd("stat failed", `TSOFC_STAT_OFF, 32'h0000_0007);
    ev(4'h4);
    ev(4'h1);
    ev(4'h4);
    ev(4'h0);
    rd("scf once", `TSOFC_SCF_OFF, 32'h0000_0001);
    ev(4'h8);
    ev(4'h2);
    ev(4'h1);
    ev(4'h0);
    rd("scf paylen", `TSOFC_SCF_OFF, 32'h0000_0002);
    tx_enable <= 1'b0;
    ev(4'h8);
    ev(4'h4);
    ev(4'h1);
    ev(4'h0);
    rd("scf txoff", `TSOFC_SCF_OFF, 32'h0000_0002);
    rd("stat", `TSOFC_STAT_OFF, 32'h0000_0000);
  endtask : t_fail
  task automatic t_ctrl();
    // Freeze write with byte lane 0 off must be ignored
    pstrb <= 4'hE;
    apb(1'b1, `TSOFC_CTRL_OFF, 32'h0000_0001);
    rd("ctrl lane0 off", `TSOFC_CTRL_OFF, 32'h0000_0000);
    pstrb <= 4'hF;
    apb(1'b1, `TSOFC_CTRL_OFF, 32'h0000_0001);
    legacy_irq <= 1'b1;
    @(posedge pclk);
    legacy_irq <= 1'b0;
    rd("iat frozen", `TSOFC_IAT_OFF, 32'h0000_0003);
    rd("ctrl", `TSOFC_CTRL_OFF, 32'h0000_0001);
    apb(1'b1, `TSOFC_CTRL_OFF, 32'h0000_0002);
    rd("iat clr", `TSOFC_IAT_OFF, 32'h0000_0000);
    rd("scf clr", `TSOFC_SCF_OFF, 32'h0000_0000);
  endtask : t_ctrl
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_irq();
    t_fail();
    t_ctrl();
    end_of_test();
  end
endmodule : tso_fail_irq_stat_counters_bench
